// ==== verilog/tfrm_pkg.sv ====
// tfrm_pkg: offsets, reset values and field positions of the register map
package tfrm_pkg;
  // register offsets
  localparam logic [7:0] OFF_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] OFF_REMOTE_TEMP_HI = 8'h01;
  localparam logic [7:0] OFF_ALERT_STATUS = 8'h02;
  localparam logic [7:0] OFF_CONFIG = 8'h03;
  localparam logic [7:0] OFF_CONV_RATE = 8'h04;
  localparam logic [7:0] OFF_LOCAL_HI_LIM = 8'h05;
  localparam logic [7:0] OFF_REMOTE_HI_LIM_HI = 8'h07;
  localparam logic [7:0] OFF_REMOTE_LO_LIM_HI = 8'h08;
  localparam logic [7:0] OFF_CONFIG_MIR = 8'h09;
  localparam logic [7:0] OFF_CONV_RATE_MIR = 8'h0a;
  localparam logic [7:0] OFF_LOCAL_HI_LIM_MIR = 8'h0b;
  localparam logic [7:0] OFF_REMOTE_HI_LIM_HI_MIR = 8'h0d;
  localparam logic [7:0] OFF_REMOTE_LO_LIM_HI_MIR = 8'h0e;
  localparam logic [7:0] OFF_SINGLE_CONV = 8'h0f;
  localparam logic [7:0] OFF_REMOTE_TEMP_LO = 8'h10;
  localparam logic [7:0] OFF_REMOTE_OFS_HI = 8'h11;
  localparam logic [7:0] OFF_REMOTE_OFS_LO = 8'h12;
  localparam logic [7:0] OFF_REMOTE_HI_LIM_LO = 8'h13;
  localparam logic [7:0] OFF_REMOTE_LO_LIM_LO = 8'h14;
  localparam logic [7:0] OFF_ALERT_MASK = 8'h16;
  localparam logic [7:0] OFF_CRIT_LIMIT = 8'h19;
  localparam logic [7:0] OFF_PIN_IN = 8'h1a;
  localparam logic [7:0] OFF_PIN_OUT = 8'h1b;
  localparam logic [7:0] OFF_CRIT_HYST = 8'h21;
  localparam logic [7:0] OFF_TACH_CNT_LO = 8'h46;
  localparam logic [7:0] OFF_TACH_CNT_HI = 8'h47;
  localparam logic [7:0] OFF_TACH_LIM_LO = 8'h48;
  localparam logic [7:0] OFF_TACH_LIM_HI = 8'h49;
  localparam logic [7:0] OFF_FAN_CTRL = 8'h4a;
  localparam logic [7:0] OFF_FAN_SPINUP = 8'h4b;
  localparam logic [7:0] OFF_FAN_DUTY = 8'h4c;
  localparam logic [7:0] OFF_FAN_FREQ = 8'h4d;
  localparam logic [7:0] OFF_LUT_HYST = 8'h4f;
  localparam logic [7:0] OFF_LUT_BASE = 8'h50;
  localparam logic [7:0] OFF_READ_FILTER = 8'hbf;
  localparam logic [7:0] OFF_MAKER = 8'hfe;
  localparam logic [7:0] OFF_DIE_REV = 8'hff;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_CONV_RATE = 8'h08;
  localparam logic [7:0] RST_HI_LIM = 8'h46;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ALERT_MASK = 8'ha4;
  localparam logic [7:0] RST_CRIT_LIMIT = 8'h55;
  localparam logic [7:0] RST_CRIT_HYST = 8'h0a;
  localparam logic [7:0] RST_TACH_LIM = 8'hff;
  localparam logic [7:0] RST_FAN_CTRL = 8'h20;
  localparam logic [7:0] RST_FAN_SPINUP = 8'h3f;
  localparam logic [7:0] RST_FAN_DUTY = 8'h00;
  localparam logic [7:0] RST_FAN_FREQ = 8'h17;
  localparam logic [7:0] RST_LUT_HYST = 8'h04;
  // fields
  localparam int FAN_PROG_BIT = 5;
  localparam int PIN_COUNT = 5;
  localparam int LUT_DEPTH = 16;
  // identity values: arbitrary, neutral
  localparam logic [7:0] ID_MAKER = 8'h5a;
  localparam logic [7:0] ID_DIE_REV = 8'ha5;
endpackage : tfrm_pkg

// ==== verilog/tfrm_strap_capture.sv ====
// tfrm_strap_capture: two-stage sync plus one load after reset release
`timescale 1ns/1ns
module tfrm_strap_capture
  import tfrm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [PIN_COUNT-1:0] pins_i,
  output logic [PIN_COUNT-1:0] sync_o,
  output logic load_o
);
  logic [PIN_COUNT-1:0] meta_reg;
  logic [1:0] stage_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= pins_i;
      sync_o <= meta_reg;
    end
  end

  // load pulses once, after the sync chain holds a real pin sample
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_reg <= 2'h0;
      load_o <= 1'b0;
    end else begin
      load_o <= (stage_reg == 2'h1);
      if (stage_reg != 2'h3) begin
        stage_reg <= stage_reg + 2'h1;
      end
    end
  end
endmodule : tfrm_strap_capture

// ==== verilog/tfrm_regs.sv ====
// tfrm_regs: register file of the thermal and fan controller
// Functional notes
// - mirror addresses reach the primary register
// - reserved addresses hold no register
// - duty value read-only unless override set
// - override set: duty and table writable
// - input levels register captures pin levels
// - output register loads from strap pins
// - threshold registers take their reset values
// - offset registers read/write, reset zero
// - filter register read/write, reset zero
`timescale 1ns/1ns
module tfrm_regs
  import tfrm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic [7:0] local_temp_i,
  input wire logic [7:0] remote_temp_hi_i,
  input wire logic [7:0] remote_temp_lo_i,
  input wire logic [7:0] alert_status_i,
  input wire logic [7:0] tach_count_lo_i,
  input wire logic [7:0] tach_count_hi_i,
  input wire logic [7:0] table_duty_i,
  input wire logic [PIN_COUNT-1:0] general_purpose_io_pins_i,
  input wire logic [PIN_COUNT-1:0] default_strap_pins_i,
  output logic [7:0] configuration_o,
  output logic [7:0] conversion_rate_o,
  output logic [7:0] fan_pwm_control_o,
  output logic [7:0] fan_spinup_config_o,
  output logic [7:0] fan_duty_value_o,
  output logic [7:0] fan_pwm_frequency_o,
  output logic [PIN_COUNT-1:0] pin_output_levels_o,
  output logic conversion_start_o
);
  logic [7:0] local_hi_lim_reg;
  logic [7:0] rem_hi_lim_hi_reg;
  logic [7:0] rem_lo_lim_hi_reg;
  logic [7:0] rem_hi_lim_lo_reg;
  logic [7:0] rem_lo_lim_lo_reg;
  logic [7:0] rem_ofs_hi_reg;
  logic [7:0] rem_ofs_lo_reg;
  logic [7:0] alert_mask_reg;
  logic [7:0] crit_limit_reg;
  logic [7:0] crit_hyst_reg;
  logic [7:0] tach_lim_lo_reg;
  logic [7:0] tach_lim_hi_reg;
  logic [7:0] lut_hyst_reg;
  logic [7:0] read_filter_reg;
  logic [PIN_COUNT-1:0] pin_in_reg;
  logic [7:0] lut_mem [LUT_DEPTH];
  logic [7:0] addr_n;
  logic [7:0] rd_next;
  logic prog_en;
  logic lut_hit;
  logic [PIN_COUNT-1:0] gpio_sync;
  logic [PIN_COUNT-1:0] strap_sync;
  logic gpio_load;

  // pins cross into the clock domain before anyone looks at them
  tfrm_strap_capture u_gpio_cap (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pins_i(general_purpose_io_pins_i),
    .sync_o(gpio_sync),
    .load_o(gpio_load)
  );
  tfrm_strap_capture u_strap_cap (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .pins_i(default_strap_pins_i),
    .sync_o(strap_sync),
    .load_o()
  );

  // fold mirror addresses onto their primary offsets
  always_comb begin
    case (addr_i)
      OFF_CONFIG_MIR: addr_n = OFF_CONFIG;
      OFF_CONV_RATE_MIR: addr_n = OFF_CONV_RATE;
      OFF_LOCAL_HI_LIM_MIR: addr_n = OFF_LOCAL_HI_LIM;
      OFF_REMOTE_HI_LIM_HI_MIR: addr_n = OFF_REMOTE_HI_LIM_HI;
      OFF_REMOTE_LO_LIM_HI_MIR: addr_n = OFF_REMOTE_LO_LIM_HI;
      default: addr_n = addr_i;
    endcase
  end

  assign prog_en = fan_pwm_control_o[FAN_PROG_BIT];
  assign lut_hit = (addr_n[7:4] == OFF_LUT_BASE[7:4]);

  // thermal config, rate, thresholds, alert mask and trims; unlisted offsets store nothing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      configuration_o <= RST_CONFIG;
      conversion_rate_o <= RST_CONV_RATE;
      local_hi_lim_reg <= RST_HI_LIM;
      rem_hi_lim_hi_reg <= RST_HI_LIM;
      rem_lo_lim_hi_reg <= RST_ZERO;
      rem_hi_lim_lo_reg <= RST_ZERO;
      rem_lo_lim_lo_reg <= RST_ZERO;
      crit_limit_reg <= RST_CRIT_LIMIT;
      crit_hyst_reg <= RST_CRIT_HYST;
      rem_ofs_hi_reg <= RST_ZERO;
      rem_ofs_lo_reg <= RST_ZERO;
      read_filter_reg <= RST_ZERO;
      alert_mask_reg <= RST_ALERT_MASK;
    end else if (wr_en_i) begin
      case (addr_n)
        OFF_CONFIG: configuration_o <= wr_data_i;
        OFF_CONV_RATE: conversion_rate_o <= wr_data_i;
        OFF_LOCAL_HI_LIM: local_hi_lim_reg <= wr_data_i;
        OFF_REMOTE_HI_LIM_HI: rem_hi_lim_hi_reg <= wr_data_i;
        OFF_REMOTE_LO_LIM_HI: rem_lo_lim_hi_reg <= wr_data_i;
        OFF_REMOTE_HI_LIM_LO: rem_hi_lim_lo_reg <= wr_data_i;
        OFF_REMOTE_LO_LIM_LO: rem_lo_lim_lo_reg <= wr_data_i;
        OFF_CRIT_LIMIT: crit_limit_reg <= wr_data_i;
        OFF_CRIT_HYST: crit_hyst_reg <= wr_data_i;
        OFF_REMOTE_OFS_HI: rem_ofs_hi_reg <= wr_data_i;
        OFF_REMOTE_OFS_LO: rem_ofs_lo_reg <= wr_data_i;
        OFF_READ_FILTER: read_filter_reg <= wr_data_i;
        OFF_ALERT_MASK: alert_mask_reg <= wr_data_i;
        default: ; // reserved holes ignore writes
      endcase
    end
  end

  // fan setup registers; the host orders its writes, we only store them
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fan_pwm_control_o <= RST_FAN_CTRL;
      fan_spinup_config_o <= RST_FAN_SPINUP;
      fan_pwm_frequency_o <= RST_FAN_FREQ;
      tach_lim_lo_reg <= RST_TACH_LIM;
      tach_lim_hi_reg <= RST_TACH_LIM;
      lut_hyst_reg <= RST_LUT_HYST;
    end else if (wr_en_i) begin
      case (addr_n)
        OFF_FAN_CTRL: fan_pwm_control_o <= wr_data_i;
        OFF_FAN_SPINUP: fan_spinup_config_o <= wr_data_i;
        OFF_FAN_FREQ: fan_pwm_frequency_o <= wr_data_i;
        OFF_TACH_LIM_LO: tach_lim_lo_reg <= wr_data_i;
        OFF_TACH_LIM_HI: tach_lim_hi_reg <= wr_data_i;
        OFF_LUT_HYST: lut_hyst_reg <= wr_data_i;
        default: ;
      endcase
    end
  end

  // duty value: host-owned while override set, else follows the table
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fan_duty_value_o <= RST_FAN_DUTY;
    end else if (prog_en) begin
      if (wr_en_i && addr_n == OFF_FAN_DUTY) begin
        fan_duty_value_o <= wr_data_i;
      end
    end else begin
      fan_duty_value_o <= table_duty_i;
    end
  end

  // lookup table is writable only under override; no reset on storage
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i && lut_hit && prog_en) begin
      lut_mem[addr_n[3:0]] <= wr_data_i;
    end
  end

  // pin levels captured once after reset; trade: sampled two edges late
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_in_reg <= '0;
      pin_output_levels_o <= '0;
    end else if (gpio_load) begin
      pin_in_reg <= gpio_sync;
      pin_output_levels_o <= strap_sync;
    end else if (wr_en_i && addr_n == OFF_PIN_OUT) begin
      pin_output_levels_o <= wr_data_i[PIN_COUNT-1:0];
    end
  end

  // single conversion trigger: pulse only, nothing kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conversion_start_o <= 1'b0;
    end else begin
      conversion_start_o <= wr_en_i && (addr_n == OFF_SINGLE_CONV);
    end
  end

  // read mux; write-only and reserved offsets read zero
  always_comb begin
    rd_next = 8'h00;
    if (lut_hit) begin
      rd_next = lut_mem[addr_n[3:0]];
    end else begin
      case (addr_n)
        OFF_LOCAL_TEMP: rd_next = local_temp_i;
        OFF_REMOTE_TEMP_HI: rd_next = remote_temp_hi_i;
        OFF_ALERT_STATUS: rd_next = alert_status_i;
        OFF_CONFIG: rd_next = configuration_o;
        OFF_CONV_RATE: rd_next = conversion_rate_o;
        OFF_LOCAL_HI_LIM: rd_next = local_hi_lim_reg;
        OFF_REMOTE_HI_LIM_HI: rd_next = rem_hi_lim_hi_reg;
        OFF_REMOTE_LO_LIM_HI: rd_next = rem_lo_lim_hi_reg;
        OFF_REMOTE_TEMP_LO: rd_next = remote_temp_lo_i;
        OFF_REMOTE_OFS_HI: rd_next = rem_ofs_hi_reg;
        OFF_REMOTE_OFS_LO: rd_next = rem_ofs_lo_reg;
        OFF_REMOTE_HI_LIM_LO: rd_next = rem_hi_lim_lo_reg;
        OFF_REMOTE_LO_LIM_LO: rd_next = rem_lo_lim_lo_reg;
        OFF_ALERT_MASK: rd_next = alert_mask_reg;
        OFF_CRIT_LIMIT: rd_next = crit_limit_reg;
        OFF_PIN_IN: rd_next = {3'h0, pin_in_reg};
        OFF_PIN_OUT: rd_next = {3'h0, pin_output_levels_o};
        OFF_CRIT_HYST: rd_next = crit_hyst_reg;
        OFF_TACH_CNT_LO: rd_next = tach_count_lo_i;
        OFF_TACH_CNT_HI: rd_next = tach_count_hi_i;
        OFF_TACH_LIM_LO: rd_next = tach_lim_lo_reg;
        OFF_TACH_LIM_HI: rd_next = tach_lim_hi_reg;
        OFF_FAN_CTRL: rd_next = fan_pwm_control_o;
        OFF_FAN_SPINUP: rd_next = fan_spinup_config_o;
        OFF_FAN_DUTY: rd_next = fan_duty_value_o;
        OFF_FAN_FREQ: rd_next = fan_pwm_frequency_o;
        OFF_LUT_HYST: rd_next = lut_hyst_reg;
        OFF_READ_FILTER: rd_next = read_filter_reg;
        OFF_MAKER: rd_next = ID_MAKER;
        OFF_DIE_REV: rd_next = ID_DIE_REV;
        default: rd_next = 8'h00;
      endcase
    end
  end

  // read data registered; one cycle latency
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= rd_next;
      end
    end
  end

  // trigger write as taken at the clock edge
  sequence s_trigger_taken;
    wr_en_i && addr_i == OFF_SINGLE_CONV;
  endsequence
  // pulse drops unless a second trigger write was taken meanwhile
  sequence s_pulse_once;
    conversion_start_o
    ##1 (conversion_start_o == $past(wr_en_i && addr_i == OFF_SINGLE_CONV));
  endsequence
  // any write that lands in the lookup table window
  sequence s_lut_write;
    wr_en_i && lut_hit;
  endsequence

  // rule checks; strobes are looked at on the edge that takes them
  a_mirror_read: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_en_i && addr_i == OFF_CONFIG_MIR
    |=> rd_data_o == $past(configuration_o))
    else $error("mirror read differs from primary");
  a_mirror_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == OFF_CONV_RATE_MIR
    |=> conversion_rate_o == $past(wr_data_i))
    else $error("mirror write missed primary");
  a_hole_reads_zero: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_en_i && (addr_i == 8'h06 || addr_i == 8'h4e) |=> rd_data_o == 8'h00)
    else $error("reserved address read nonzero");
  a_hole_write_inert: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && (addr_i == 8'h06 || addr_i == 8'h4e)
    |=> $stable(configuration_o) && $stable(conversion_rate_o)
    && $stable(fan_pwm_control_o) && $stable(fan_pwm_frequency_o))
    else $error("reserved address write changed a register");
  a_duty_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == OFF_FAN_DUTY && !prog_en && wr_data_i != table_duty_i
    |=> fan_duty_value_o != $past(wr_data_i))
    else $error("duty written while locked");
  a_duty_follows: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !prog_en |=> fan_duty_value_o == $past(table_duty_i))
    else $error("duty not following the table while locked");
  a_duty_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == OFF_FAN_DUTY && prog_en
    |=> fan_duty_value_o == $past(wr_data_i))
    else $error("duty write lost under override");
  a_table_write: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_lut_write ##0 prog_en
    |=> lut_mem[$past(addr_n[3:0])] == $past(wr_data_i))
    else $error("table write lost under override");
  a_table_locked: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_lut_write ##0 !prog_en
    |=> lut_mem[$past(addr_n[3:0])] == $past(lut_mem[addr_n[3:0]]))
    else $error("table written while locked");
  a_gpin_capture: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    gpio_load |=> pin_in_reg == $past(gpio_sync))
    else $error("input levels not captured");
  a_strap_load: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    gpio_load |=> pin_output_levels_o == $past(strap_sync))
    else $error("output levels not loaded from straps");
  a_limit_reset: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> local_hi_lim_reg == RST_HI_LIM
    && rem_hi_lim_hi_reg == RST_HI_LIM && rem_lo_lim_hi_reg == RST_ZERO
    && rem_hi_lim_lo_reg == RST_ZERO && rem_lo_lim_lo_reg == RST_ZERO
    && crit_limit_reg == RST_CRIT_LIMIT && crit_hyst_reg == RST_CRIT_HYST)
    else $error("threshold register not at reset value");
  a_trim_reset: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> rem_ofs_hi_reg == RST_ZERO
    && rem_ofs_lo_reg == RST_ZERO && read_filter_reg == RST_ZERO)
    else $error("trim register not at reset value");
  a_offset_store: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == OFF_REMOTE_OFS_HI
    |=> rem_ofs_hi_reg == $past(wr_data_i))
    else $error("offset write lost");
  a_filter_store: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_en_i && addr_i == OFF_READ_FILTER
    |=> read_filter_reg == $past(wr_data_i))
    else $error("filter write lost");
  a_trigger_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_trigger_taken |=> s_pulse_once)
    else $error("single conversion pulse wrong");
endmodule : tfrm_regs

// ==== verification/tfrm_host_model.sv ====
// tfrm_host_model: host side of the register strobes and fan bring-up
`timescale 1ns/1ns
module tfrm_host_model
  import tfrm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wr_data_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wr_data_o = 8'h00;
  end
  // one write: request launched after an edge, held over one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    wr_en_o = 1'b1;
    addr_o = a;
    wr_data_o = d;
    @(posedge clk_sys_i);
    #1;
    wr_en_o = 1'b0;
    // idle lines carry inverted junk so a stale value never looks valid
    addr_o = ~a;
    wr_data_o = ~d;
  endtask : wr
  // one read: answer is sampled in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk_sys_i);
    #1;
    rd_en_o = 1'b1;
    addr_o = a;
    @(posedge clk_sys_i);
    #1;
    d = rd_data_i;
    v = rd_valid_i;
    rd_en_o = 1'b0;
    addr_o = ~a;
  endtask : rd
  // fan bring-up before any fan use; lut_path picks step four's branch
  task automatic fan_setup(input logic lut_path, input logic [7:0] ctl,
                           input logic [7:0] spin, input logic [7:0] freq,
                           input logic [7:0] duty);
    wr(OFF_FAN_CTRL, ctl | 8'h20);
    wr(OFF_FAN_SPINUP, spin);
    wr(OFF_FAN_FREQ, freq);
    if (lut_path) begin
      for (int i = 0; i < 17; i++) begin
        wr(OFF_LUT_HYST + i[7:0], duty + i[7:0]);
      end
      wr(OFF_FAN_CTRL, ctl & 8'hdf);
    end else begin
      wr(OFF_FAN_DUTY, duty);
    end
  endtask : fan_setup
endmodule : tfrm_host_model

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench of the thermal and fan register file
`timescale 1ns/1ns
module tb_top
  import tfrm_pkg::*;
;
  logic clk_sys_i, rst_n_i, wr_en_i, rd_en_i, rd_valid_o, conversion_start_o;
  logic [7:0] addr_i, wr_data_i, rd_data_o, local_temp_i, remote_temp_hi_i;
  logic [7:0] remote_temp_lo_i, alert_status_i, tach_count_lo_i;
  logic [7:0] tach_count_hi_i, table_duty_i, configuration_o;
  logic [7:0] conversion_rate_o, fan_pwm_control_o, fan_spinup_config_o;
  logic [7:0] fan_duty_value_o, fan_pwm_frequency_o;
  logic [4:0] gpio_pins, strap_pins, pin_output_levels_o;
  int err_total = 0;
  int checks_done = 0;
  // address in the high byte, expected value after reset in the low byte
  logic [15:0] rst_tab [0:25] = '{16'h0300, 16'h0408, 16'h0546, 16'h0746,
    16'h0800, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h16a4, 16'h1955,
    16'h210a, 16'h48ff, 16'h49ff, 16'h4a20, 16'h4b3f, 16'h4c00, 16'h4d17,
    16'h4f04, 16'hbf00, 16'h003c, 16'h0141, 16'h10e0, 16'h0248, 16'h469c,
    16'h4712};
  logic [15:0] mir_tab [0:4] = '{16'h0309, 16'h040a, 16'h050b, 16'h070d,
    16'h080e};
  logic [7:0] hole_tab [0:16] = '{8'h06, 8'h0c, 8'h15, 8'h17, 8'h18, 8'h1c,
    8'h1f, 8'h20, 8'h22, 8'h3f, 8'h40, 8'h45, 8'h4e, 8'h60, 8'hbe, 8'hc0,
    8'hfd};

  tfrm_regs tfrm_regs_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .local_temp_i(local_temp_i), .remote_temp_hi_i(remote_temp_hi_i),
    .remote_temp_lo_i(remote_temp_lo_i), .alert_status_i(alert_status_i),
    .tach_count_lo_i(tach_count_lo_i), .tach_count_hi_i(tach_count_hi_i),
    .table_duty_i(table_duty_i), .general_purpose_io_pins_i(gpio_pins),
    .default_strap_pins_i(strap_pins), .configuration_o(configuration_o),
    .conversion_rate_o(conversion_rate_o),
    .fan_pwm_control_o(fan_pwm_control_o),
    .fan_spinup_config_o(fan_spinup_config_o),
    .fan_duty_value_o(fan_duty_value_o),
    .fan_pwm_frequency_o(fan_pwm_frequency_o),
    .pin_output_levels_o(pin_output_levels_o),
    .conversion_start_o(conversion_start_o));

  tfrm_host_model tfrm_host_model_inst (.clk_sys_i(clk_sys_i),
    .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o), .wr_en_o(wr_en_i),
    .rd_en_o(rd_en_i), .addr_o(addr_i), .wr_data_o(wr_data_i));

  // 250 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // read through the host model, checking the valid pulse as well
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    tfrm_host_model_inst.rd(a, d, v);
    chk("rd_valid_o", 8'h01, {7'h00, v});
    chk($sformatf("read of %h", a), e, d);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tfrm_host_model_inst.wr(a, d);
  endtask : wr
  // pins settle before release so the strap sample sees stable levels
  task automatic do_reset(input logic [4:0] gp, input logic [4:0] sp);
    @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b0;
    gpio_pins = gp;
    strap_pins = sp;
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
  endtask : do_reset
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // a hung handshake must not stall the run
  initial begin
    #100000;
    err_total++;
    summarize();
  end

  initial begin
    rst_n_i = 1'b0;
    local_temp_i = 8'h3c;
    remote_temp_hi_i = 8'h41;
    remote_temp_lo_i = 8'he0;
    alert_status_i = 8'h48;
    tach_count_lo_i = 8'h9c;
    tach_count_hi_i = 8'h12;
    table_duty_i = 8'h33;
    gpio_pins = 5'h15;
    strap_pins = 5'h0a;
    do_reset(5'h15, 5'h0a);
    foreach (rst_tab[i]) begin
      rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
    end
    rchk(OFF_MAKER, ID_MAKER);
    rchk(OFF_DIE_REV, ID_DIE_REV);
    rchk(OFF_PIN_IN, 8'h15);
    rchk(OFF_PIN_OUT, 8'h0a);
    chk("pin_output_levels_o", 8'h0a, {3'h0, pin_output_levels_o});
    $display("test reset_values done");
    // second reset mid-run with swapped pin levels must reload both
    wr(OFF_PIN_OUT, 8'h1f);
    do_reset(5'h0a, 5'h15);
    rchk(OFF_PIN_IN, 8'h0a);
    rchk(OFF_PIN_OUT, 8'h15);
    wr(OFF_PIN_OUT, 8'h07);
    chk("pin_output_levels_o", 8'h07, {3'h0, pin_output_levels_o});
    $display("test pin_capture done");
    foreach (mir_tab[i]) begin
      wr(mir_tab[i][15:8], 8'h60 + i[7:0]);
      rchk(mir_tab[i][7:0], 8'h60 + i[7:0]);
      wr(mir_tab[i][7:0], 8'h90 + i[7:0]);
      rchk(mir_tab[i][15:8], 8'h90 + i[7:0]);
    end
    chk("configuration_o", 8'h90, configuration_o);
    chk("conversion_rate_o", 8'h91, conversion_rate_o);
    $display("test mirrors done");
    wr(OFF_REMOTE_OFS_HI, 8'hc3);
    wr(OFF_REMOTE_OFS_LO, 8'ha0);
    wr(OFF_READ_FILTER, 8'h07);
    rchk(OFF_REMOTE_OFS_HI, 8'hc3);
    rchk(OFF_REMOTE_OFS_LO, 8'ha0);
    rchk(OFF_READ_FILTER, 8'h07);
    $display("test trims done");
    foreach (hole_tab[i]) begin
      wr(hole_tab[i], 8'hff);
      rchk(hole_tab[i], 8'h00);
    end
    rchk(OFF_LOCAL_HI_LIM, 8'h92);
    wr(OFF_LOCAL_TEMP, 8'hff);
    rchk(OFF_LOCAL_TEMP, 8'h3c);
    wr(OFF_PIN_IN, 8'hff);
    rchk(OFF_PIN_IN, 8'h0a);
    wr(OFF_TACH_CNT_LO, 8'h00);
    rchk(OFF_TACH_CNT_LO, 8'h9c);
    $display("test holes_and_read_only done");
    wr(OFF_SINGLE_CONV, 8'h5c);
    chk("conversion_start_o", 8'h01, {7'h00, conversion_start_o});
    @(posedge clk_sys_i);
    #1;
    chk("conversion_start_o", 8'h00, {7'h00, conversion_start_o});
    rchk(OFF_SINGLE_CONV, 8'h00);
    $display("test single_conversion done");
    tfrm_host_model_inst.fan_setup(1'b0, 8'h1b, 8'h2d, 8'h0f, 8'h25);
    chk("fan_pwm_control_o", 8'h3b, fan_pwm_control_o);
    chk("fan_spinup_config_o", 8'h2d, fan_spinup_config_o);
    chk("fan_pwm_frequency_o", 8'h0f, fan_pwm_frequency_o);
    chk("fan_duty_value_o", 8'h25, fan_duty_value_o);
    rchk(OFF_FAN_DUTY, 8'h25);
    tfrm_host_model_inst.fan_setup(1'b1, 8'h0b, 8'h1a, 8'h11, 8'h40);
    chk("fan_pwm_control_o", 8'h0b, fan_pwm_control_o);
    rchk(OFF_LUT_HYST, 8'h40);
    rchk(8'h55, 8'h46);
    wr(OFF_FAN_DUTY, 8'h01);
    rchk(OFF_FAN_DUTY, 8'h33);
    wr(8'h55, 8'hee);
    rchk(8'h55, 8'h46);
    table_duty_i = 8'h2e;
    rchk(OFF_FAN_DUTY, 8'h2e);
    chk("fan_duty_value_o", 8'h2e, fan_duty_value_o);
    $display("test fan_setup done");
    summarize();
  end
endmodule : tb_top
